/* gpio_pin_sense_security.sv */
// 32-pin general purpose port with level sense, latched match and split security
// assumes synchronous pad inputs and a plain strobe register port
//
// Behaviour
// - 32 pins, each with own configuration
// - disconnected input buffer gives zero input
// - input register lags pad two clocks
// - sense field picks high, low or off
// - per pin match when level matches
// - default port match is OR of pins
// - sense logic runs in all power states
// - enable on matching level raises match
// - rising pin match sets sticky flag
// - flag clears by one, not while matching
// - falling match leaves flags unchanged
// - latched match high while flag set
// - clear leaving flags set regenerates edge
// - flags readable any time, any source
// - selector switches output to latched match
// - peripherals override output, read input
// - nonsecure access masks secure pin bits
// - masked access ignored without error
// - secure pin config hidden from nonsecure
// - secure selector hidden from nonsecure
// - nonsecure selector drives nonsecure output
// - separate outputs to two event units
`timescale 1ns/1ps
`include "gpio_sense_defs.svh"
module gpio_pin_sense_security
  import gpio_sense_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire bus_req_s bus_i,
  output logic [31:0] rdata_o,
  input wire logic [31:0] pad_in_i,
  input wire logic [31:0] pin_permission_i,
  input wire logic [31:0] periph_own_i,
  input wire logic [31:0] periph_out_i,
  input wire logic [31:0] periph_dir_i,
  output logic [31:0] pad_out_o,
  output logic [31:0] pad_oe_n_o,
  output logic [31:0] periph_in_o,
  output logic [31:0] pin_config_flat_o,
  output logic nonsecure_pin_match_o,
  output logic secure_pin_match_o
);
  localparam int NP = `GP_NPINS;
  logic [31:0] out_r;
  logic [31:0] dir_r;
  logic [31:0] latch_r;
  logic [31:0] latch_nxt;
  logic [31:0] sync1_r;
  logic [31:0] sync2_r;
  logic [31:0] pin_match_r;
  logic [31:0] pin_match_d_r;
  logic [31:0] cfg_r [NP];
  logic ns_mode_r;
  logic s_mode_r;
  logic ns_lm_r;
  logic s_lm_r;
  logic [31:0] rdata_r;
  // nonsecure access may touch only nonsecure pins
  wire logic [31:0] wmask = bus_i.secure ? 32'hffffffff : ~pin_permission_i;
  wire logic [11:0] a = bus_i.addr;
  wire logic in_cfg = (a >= `GP_OFF_CFG_BASE) && (a <= `GP_OFF_CFG_LAST) && (a[1:0] == 2'h0);
  wire logic [4:0] cfg_idx = a[6:2];
  wire logic cfg_ok = bus_i.secure | ~pin_permission_i[cfg_idx];
  wire logic wr_out = bus_i.wr && a == `GP_OFF_OUT;
  wire logic wr_oset = bus_i.wr && a == `GP_OFF_OUTSET;
  wire logic wr_oclr = bus_i.wr && a == `GP_OFF_OUTCLR;
  wire logic wr_dir = bus_i.wr && a == `GP_OFF_DIR;
  wire logic wr_dset = bus_i.wr && a == `GP_OFF_DIRSET;
  wire logic wr_dclr = bus_i.wr && a == `GP_OFF_DIRCLR;
  wire logic wr_latch = bus_i.wr && a == `GP_OFF_LATCH;
  wire logic wr_nsm = bus_i.wr && a == `GP_OFF_NS_MODE;
  wire logic wr_sm = bus_i.wr && a == `GP_OFF_S_MODE && bus_i.secure;
  wire logic [31:0] wd = bus_i.data & wmask;
  wire logic [31:0] out_nxt = wr_out ? ((out_r & ~wmask) | wd) :
                              wr_oset ? (out_r | wd) : wr_oclr ? (out_r & ~wd) : out_r;
  wire logic [31:0] dir_nxt = wr_dir ? ((dir_r & ~wmask) | wd) :
                              wr_dset ? (dir_r | wd) : wr_dclr ? (dir_r & ~wd) : dir_r;
  // per-pin input gating, sense and output muxing
  logic [31:0] pad_gated;
  logic [31:0] match_nxt;
  logic [31:0] pout_nxt;
  logic [31:0] poe_nxt;
  logic [31:0] cfg_dir_bits;
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pin
      wire logic [1:0] sense = cfg_r[g][`GP_CFG_SENSE_HI:`GP_CFG_SENSE_LO];
      assign pad_gated[g] = pad_in_i[g] & ~cfg_r[g][`GP_CFG_INDIS_BIT];
      // a disconnected input buffer keeps the pin out of the sense logic
      wire logic conn = ~cfg_r[g][`GP_CFG_INDIS_BIT];
      assign match_nxt[g] = ~conn ? 1'b0 :
                            (sense == `GP_SENSE_HIGH) ? sync2_r[g] :
                            (sense == `GP_SENSE_LOW) ? ~sync2_r[g] : 1'b0;
      assign cfg_dir_bits[g] = cfg_r[g][`GP_CFG_DIR_BIT] | dir_r[g];
      assign pout_nxt[g] = periph_own_i[g] ? periph_out_i[g] : out_r[g];
      assign poe_nxt[g] = ~(periph_own_i[g] ? periph_dir_i[g] : cfg_dir_bits[g]);
      always_ff @(posedge clk_sys_i or negedge nrst_i)
      begin
        if (!nrst_i)
          cfg_r[g] <= `GP_CFG_RESET;
        else if (bus_i.wr && in_cfg && cfg_ok && cfg_idx == 5'(g))
          cfg_r[g] <= bus_i.data & `GP_CFG_MASK;
      end
    end
  endgenerate
  // sticky flags: rising match sets, one clears unless still matching; falling leaves alone
  wire logic [31:0] rise = pin_match_r & ~pin_match_d_r;
  wire logic [31:0] clr = wr_latch ? (wd & ~pin_match_r) : 32'h0;
  assign latch_nxt = (latch_r & ~clr) | rise | (latch_r & pin_match_r);
  wire logic [31:0] ns_pins = ~pin_permission_i;
  wire logic [31:0] s_pins = pin_permission_i;
  wire logic ns_any_nxt = |(latch_nxt & ns_pins);
  wire logic s_any_nxt = |(latch_nxt & s_pins);
  // a clear that leaves flags set drops the latched match for one cycle
  wire logic ns_clr_hit = wr_latch && |(clr & ns_pins);
  wire logic s_clr_hit = wr_latch && |(clr & s_pins);
  wire logic ns_lm_nxt = ns_any_nxt & ~(ns_clr_hit & ns_lm_r);
  wire logic s_lm_nxt = s_any_nxt & ~(s_clr_hit & s_lm_r);
  wire logic ns_or = |(pin_match_r & ns_pins);
  wire logic s_or = |(pin_match_r & s_pins);
  wire logic ns_det_nxt = ns_mode_r ? ns_lm_r : ns_or;
  wire logic s_det_nxt = s_mode_r ? s_lm_r : s_or;
  wire logic [31:0] cfg_rd = cfg_ok ? cfg_r[cfg_idx] : 32'h0;
  wire logic [31:0] rmask = wmask;
  wire logic sel_out = (a == `GP_OFF_OUT) || (a == `GP_OFF_OUTSET) || (a == `GP_OFF_OUTCLR);
  wire logic sel_in = (a == `GP_OFF_IN);
  wire logic sel_dir = (a == `GP_OFF_DIR) || (a == `GP_OFF_DIRSET) || (a == `GP_OFF_DIRCLR);
  wire logic sel_latch = (a == `GP_OFF_LATCH);
  wire logic sel_nsm = (a == `GP_OFF_NS_MODE);
  wire logic sel_sm = (a == `GP_OFF_S_MODE);
  wire logic [31:0] rsel =
    sel_out ? (out_r & rmask) :
    sel_in ? (sync2_r & rmask) :
    sel_dir ? (dir_r & rmask) :
    sel_latch ? (latch_r & rmask) :
    sel_nsm ? {31'h0, ns_mode_r} :
    sel_sm ? {31'h0, s_mode_r & bus_i.secure} :
    in_cfg ? cfg_rd : 32'h0;
  // sense path has no clock gating, so it runs in every power state
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_r <= 32'h0;
      sync2_r <= 32'h0;
      pin_match_r <= 32'h0;
      pin_match_d_r <= 32'h0;
    end
    else
    begin
      sync1_r <= pad_gated;
      sync2_r <= sync1_r;
      pin_match_r <= match_nxt;
      pin_match_d_r <= pin_match_r;
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      out_r <= 32'h0;
    else
      out_r <= out_nxt;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dir_r <= 32'h0;
    else
      dir_r <= dir_nxt;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      latch_r <= 32'h0;
    else
      latch_r <= latch_nxt;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ns_mode_r <= 1'b0;
    else if (wr_nsm)
      ns_mode_r <= bus_i.data[0];
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_mode_r <= 1'b0;
    else if (wr_sm)
      s_mode_r <= bus_i.data[0];
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ns_lm_r <= 1'b0;
      s_lm_r <= 1'b0;
    end
    else
    begin
      ns_lm_r <= ns_lm_nxt;
      s_lm_r <= s_lm_nxt;
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      nonsecure_pin_match_o <= 1'b0;
      secure_pin_match_o <= 1'b0;
    end
    else
    begin
      nonsecure_pin_match_o <= ns_det_nxt;
      secure_pin_match_o <= s_det_nxt;
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_r <= 32'h0;
    else
      rdata_r <= bus_i.rd ? rsel : 32'h0;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pad_out_o <= 32'h0;
    else
      pad_out_o <= pout_nxt;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pad_oe_n_o <= 32'hffffffff;
    else
      pad_oe_n_o <= poe_nxt;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      periph_in_o <= 32'h0;
    else
      periph_in_o <= sync2_r;
  end
  assign rdata_o = rdata_r;
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pin_config_flat_o <= 32'h0;
    else
      pin_config_flat_o <= cfg_dir_bits;
  end

  a_flag_sets_on_rise: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (rise != 32'h0) |=> (latch_r & $past(rise)) == $past(rise))
    else $error("flag not set on rising match");
  a_flag_hold_match: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ((latch_r & pin_match_r) != 32'h0) |=> (latch_r & $past(latch_r & pin_match_r)) == $past(latch_r & pin_match_r))
    else $error("flag cleared while matching");
  a_flag_clear_one: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    wr_latch |=> (latch_r & $past(clr & ~rise)) == 32'h0)
    else $error("flag not cleared");
  a_flag_no_fall: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!wr_latch) |=> (latch_r & ~$past(latch_r)) == ($past(rise) & ~$past(latch_r)))
    else $error("flags changed without cause");
  a_flag_no_drop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!wr_latch) |=> (~latch_r & $past(latch_r)) == 32'h0)
    else $error("flag dropped without clear");
  a_input_delay: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ##2 sync2_r == $past(pad_gated, 2)) else $error("input delay wrong");
  a_ns_mask_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.rd && !bus_i.secure && a == `GP_OFF_LATCH) |=> (rdata_o & $past(pin_permission_i)) == 32'h0)
    else $error("secure bits leaked");
  a_secmode_hidden: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.rd && !bus_i.secure && a == `GP_OFF_S_MODE) |=> rdata_o == 32'h0) else $error("secure mode visible");
  a_ns_or_source: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !ns_mode_r |=> nonsecure_pin_match_o == $past(ns_or)) else $error("ns match not or");
  a_latch_empty_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ns_lm_r && $stable(pin_permission_i)) |-> ((latch_r & ns_pins) != 32'h0))
    else $error("latched match without flag");
  a_s_or_source: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !s_mode_r |=> secure_pin_match_o == $past(s_or))
    else $error("s match not or");
  a_ns_latched_source: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ns_mode_r |=> nonsecure_pin_match_o == $past(ns_lm_r))
    else $error("ns match not latched");
  a_s_latched_source: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_mode_r |=> secure_pin_match_o == $past(s_lm_r))
    else $error("s match not latched");
  a_ns_latch_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ((|(latch_nxt & ns_pins)) && !ns_clr_hit) |=> ns_lm_r)
    else $error("ns latched match low with flag");
  a_ns_latch_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !(|(latch_nxt & ns_pins)) |=> !ns_lm_r)
    else $error("ns latched match high without flag");
  a_ns_regen_edge: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ns_clr_hit && ns_lm_r && ns_any_nxt) |=> !ns_lm_r ##1 (ns_lm_r || $past(wr_latch)))
    else $error("ns latched match not regenerated");
  a_s_regen_edge: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (s_clr_hit && s_lm_r && s_any_nxt) |=> !s_lm_r ##1 (s_lm_r || $past(wr_latch)))
    else $error("s latched match not regenerated");
  a_sync_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    1'b1 |=> sync1_r == $past(pad_gated))
    else $error("first sync stage wrong");
  a_nomatch_disc: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cfg_r[31][`GP_CFG_INDIS_BIT] |=> !pin_match_r[31])
    else $error("disconnected pin matched");
  a_sense_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (cfg_r[0][`GP_CFG_SENSE_HI:`GP_CFG_SENSE_LO] == `GP_SENSE_OFF) |=> !pin_match_r[0])
    else $error("match with sensing off");
  a_sense_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (cfg_r[5][`GP_CFG_SENSE_HI:`GP_CFG_SENSE_LO] == `GP_SENSE_HIGH && !cfg_r[5][`GP_CFG_INDIS_BIT])
    |=> pin_match_r[5] == $past(sync2_r[5])) else $error("high sense wrong");
  a_sense_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (cfg_r[3][`GP_CFG_SENSE_HI:`GP_CFG_SENSE_LO] == `GP_SENSE_LOW && !cfg_r[3][`GP_CFG_INDIS_BIT])
    |=> pin_match_r[3] == !$past(sync2_r[3])) else $error("low sense wrong");
  a_immediate_match: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ($changed(cfg_r[3]) && cfg_r[3][`GP_CFG_SENSE_HI:`GP_CFG_SENSE_LO] == `GP_SENSE_LOW
    && !cfg_r[3][`GP_CFG_INDIS_BIT] && !sync2_r[3]) |=> pin_match_r[3]) else $error("no match at enable");
  a_ns_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ($rose(pin_match_r[3]) && !pin_permission_i[3] && !ns_mode_r) |=> nonsecure_pin_match_o)
    else $error("no port event on match");
  a_ns_mask_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_out && !bus_i.secure) |=> (out_r & $past(pin_permission_i)) == $past(out_r & pin_permission_i))
    else $error("secure out bits written");
  a_ns_latch_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_latch && !bus_i.secure) |=> (~latch_r & $past(latch_r & pin_permission_i)) == 32'h0)
    else $error("secure flag cleared");
  a_cfg_ns_ignored: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.wr && !bus_i.secure && a == (`GP_OFF_CFG_BASE + 12'h01c) && pin_permission_i[7]) |=> $stable(cfg_r[7]))
    else $error("secure config written");
  a_cfg_read_ns: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.rd && in_cfg && !cfg_ok) |=> rdata_o == 32'h0)
    else $error("secure config visible");
  a_cfg_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.wr && in_cfg && cfg_ok && cfg_idx == 5'h3) |=> cfg_r[3] == ($past(bus_i.data) & `GP_CFG_MASK))
    else $error("config write lost");
  a_outset_bits: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_oset && bus_i.secure) |=> (out_r & $past(bus_i.data)) == $past(bus_i.data))
    else $error("out set lost");
  a_dirclr_bits: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_dclr && bus_i.secure) |=> (dir_r & $past(bus_i.data)) == 32'h0)
    else $error("dir clear lost");
  a_smode_ns_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.wr && !bus_i.secure && sel_sm) |=> $stable(s_mode_r))
    else $error("secure mode written by nonsecure");
  a_smode_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.wr && bus_i.secure && sel_sm) |=> s_mode_r == $past(bus_i.data[0]))
    else $error("secure mode not written");
  a_nsmode_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.wr && sel_nsm) |=> ns_mode_r == $past(bus_i.data[0]))
    else $error("nonsecure mode not written");
  a_latch_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_i.rd && sel_latch && bus_i.secure) |=> rdata_o == $past(latch_r))
    else $error("flags not readable");
  a_ns_domain_or: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ((pin_match_r & ~pin_permission_i) == 32'h0 && !ns_mode_r) |=> !nonsecure_pin_match_o)
    else $error("secure pin in ns match");
  a_s_domain_or: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ((pin_match_r & pin_permission_i) == 32'h0 && !s_mode_r) |=> !secure_pin_match_o)
    else $error("nonsecure pin in s match");
  a_periph_in: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    1'b1 |=> periph_in_o == $past(sync2_r))
    else $error("peripheral input wrong");
  a_pad_override: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    1'b1 |=> (pad_out_o & $past(periph_own_i)) == $past(periph_out_i & periph_own_i))
    else $error("output override lost");
  a_oe_override: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    1'b1 |=> (~pad_oe_n_o & $past(periph_own_i)) == $past(periph_dir_i & periph_own_i))
    else $error("direction override lost");
  c_pin_match: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) rise != 32'h0);
  c_ns_latched: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) ns_mode_r && $rose(nonsecure_pin_match_o));
  c_override: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) periph_own_i != 32'h0);
  c_latch_regen: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) ns_lm_r ##1 !ns_lm_r ##1 ns_lm_r);
  c_sec_match: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) $rose(secure_pin_match_o));
endmodule : gpio_pin_sense_security

/* gpio_sense_defs.svh */
// register offsets, field positions, reset values and timing counts for the gpio sense port
// assumes byte addressing over a plain strobe port with 32-bit data
`ifndef GPIO_SENSE_DEFS_SVH
`define GPIO_SENSE_DEFS_SVH
`define GP_NPINS 32
`define GP_AW 12
`define GP_OFF_OUT 12'h004
`define GP_OFF_OUTSET 12'h008
`define GP_OFF_OUTCLR 12'h00c
`define GP_OFF_IN 12'h010
`define GP_OFF_DIR 12'h014
`define GP_OFF_DIRSET 12'h018
`define GP_OFF_DIRCLR 12'h01c
`define GP_OFF_LATCH 12'h020
`define GP_OFF_NS_MODE 12'h024
`define GP_OFF_S_MODE 12'h028
`define GP_OFF_CFG_BASE 12'h200
`define GP_OFF_CFG_LAST 12'h27c
`define GP_CFG_DIR_BIT 0
`define GP_CFG_INDIS_BIT 1
`define GP_CFG_PULL_LO 2
`define GP_CFG_PULL_HI 3
`define GP_CFG_DRIVE_LO 8
`define GP_CFG_DRIVE_HI 10
`define GP_CFG_SENSE_LO 16
`define GP_CFG_SENSE_HI 17
`define GP_CFG_ANA_BIT 20
`define GP_CFG_MASK 32'h0013070f
`define GP_CFG_RESET 32'h00000002
`define GP_SENSE_OFF 2'h0
`define GP_SENSE_HIGH 2'h2
`define GP_SENSE_LOW 2'h3
`define GP_SYNC_STAGES 2
`endif

/* gpio_sense_pkg.sv */
// types for the gpio sense port
// assumes gpio_sense_defs.svh constants
package gpio_sense_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic secure;
  } bus_req_s;
  typedef enum logic [1:0] {
    SRC_OR = 2'h0,
    SRC_LATCH = 2'h1
  } match_src_e;
endpackage : gpio_sense_pkg

/* pad_source.sv */
// model of the external circuitry that drives the port pads
// assumes the bench asks for pad levels on want_i, in the port clock domain
`timescale 1ns/1ps
module pad_source
(
  input wire logic clk_sys_i,
  input wire logic [31:0] want_i,
  output logic [31:0] pad_o
);
  logic [1:0] hold_r [32];
  initial
  begin
    pad_o = '0;
    for (int i = 0; i < 32; i++) hold_r[i] = 2'h0;
  end
  // a new level stands at least three clocks before the pad may move again
  always @(posedge clk_sys_i)
    for (int i = 0; i < 32; i++)
      if (hold_r[i] != 2'h0) hold_r[i] <= hold_r[i] - 2'h1;
      else if (want_i[i] != pad_o[i])
      begin
        pad_o[i] <= want_i[i];
        hold_r[i] <= 2'h3;
      end
endmodule : pad_source

/* gpio_pin_sense_security_tb.sv */
// self-checking bench for the gpio sense port
// assumes the pad model above and the register offsets of the defs header
`timescale 1ns/1ps
`include "gpio_sense_defs.svh"
module gpio_pin_sense_security_tb
  import gpio_sense_pkg::*;
;
  logic clk_sys_i = 0, nrst_i = 0;
  bus_req_s bus_i = '0;
  logic [31:0] want = '0, pin_permission = '0, p_out = '0, p_dir = '0, rv, x;
  logic [31:0] rdata_o, pad_in, pad_out_o, pad_oe_n_o, periph_in_o;
  logic [31:0] own = '0, v, d;
  logic ns_m, s_m;
  int failures = 0, samples_checked = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  pad_source pad_u (.clk_sys_i(clk_sys_i), .want_i(want), .pad_o(pad_in));
  gpio_pin_sense_security dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .pad_in_i(pad_in), .pin_permission_i(pin_permission), .periph_own_i(own), .periph_out_i(p_out),
    .periph_dir_i(p_dir), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .periph_in_o(periph_in_o),
    .pin_config_flat_o(), .nonsecure_pin_match_o(ns_m), .secure_pin_match_o(s_m));
  function automatic logic [31:0] vis(logic [31:0] v, logic sec);
    return sec ? v : (v & ~pin_permission);
  endfunction : vis
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d, logic s);
    @(posedge clk_sys_i) bus_i <= '{d, a, 1'b1, 1'b0, s};
    @(posedge clk_sys_i) bus_i.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic s);
    @(posedge clk_sys_i) bus_i <= '{32'h0, a, 1'b0, 1'b1, s};
    @(posedge clk_sys_i) bus_i.rd <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd
  task automatic wait_m(logic s, logic e);
    int i;
    for (i = 0; i < 20; i++)
    begin
      if ((s ? s_m : ns_m) === e) break;
      @(posedge clk_sys_i);
      #1;
    end
    if (i == 20)
    begin
      failures++;
      conclude();
    end
  endtask : wait_m
  task automatic pads(logic [31:0] w);
    @(posedge clk_sys_i) want <= w;
    repeat (10) @(posedge clk_sys_i);
  endtask : pads
  initial
  begin
    void'($urandom(42));
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(`GP_OFF_CFG_BASE, 1'b1); chk(rv, `GP_CFG_RESET);
    rd(`GP_OFF_LATCH, 1'b1); chk(rv, 32'h0);
    for (int i = 0; i < 31; i++) wr(`GP_OFF_CFG_BASE + 12'(4 * i), 32'h0, 1'b1);
    x = $urandom;
    p_out <= $urandom;
    p_dir <= $urandom;
    pads(x);
    rd(`GP_OFF_IN, 1'b1); chk(rv, x & 32'h7fffffff);
    chk(periph_in_o, x & 32'h7fffffff);
    x = $urandom;
    wr(`GP_OFF_OUT, x, 1'b1);
    wr(`GP_OFF_DIR, ~x, 1'b1);
    rd(`GP_OFF_OUTSET, 1'b1); chk(rv, x);
    chk(pad_out_o, x);
    chk(pad_oe_n_o, x);
    d = ~x;
    for (int k = 0; k < 8; k++)
    begin
      v = $urandom;
      if (v[0])
      begin
        wr(`GP_OFF_OUTSET, v, 1'b1);
        x = x | v;
      end
      else
      begin
        wr(`GP_OFF_OUTCLR, v, 1'b1);
        x = x & ~v;
      end
      rd(`GP_OFF_OUT, 1'b1); chk(rv, x);
    end
    wr(`GP_OFF_DIRSET, 32'h000000ff, 1'b1);
    wr(`GP_OFF_DIRCLR, 32'h0000ff00, 1'b1);
    d = (d | 32'h000000ff) & ~32'h0000ff00;
    rd(`GP_OFF_DIRCLR, 1'b1); chk(rv, d);
    @(posedge clk_sys_i) own <= 32'hffff0000;
    repeat (2) @(posedge clk_sys_i);
    #1 chk(pad_out_o, (p_out & own) | (x & ~own));
    chk(pad_oe_n_o, ~((p_dir & own) | (d & ~own)));
    @(posedge clk_sys_i) own <= 32'h0;
    $display("basic test done");
    pads(32'h0);
    wr(`GP_OFF_CFG_BASE + 12'h00c, 32'h00030000, 1'b1);
    wait_m(1'b0, 1'b1);
    pads(32'h8);
    wait_m(1'b0, 1'b0);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h8);
    wr(`GP_OFF_LATCH, 32'h8, 1'b0);
    wr(`GP_OFF_CFG_BASE + 12'h014, 32'h00020000, 1'b1);
    pads(32'h28);
    wait_m(1'b0, 1'b1);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h20);
    wr(`GP_OFF_LATCH, 32'h20, 1'b0);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h20);
    pads(32'h8);
    wait_m(1'b0, 1'b0);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h20);
    wr(`GP_OFF_LATCH, 32'h20, 1'b0);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h0);
    $display("sense test done");
    wr(`GP_OFF_NS_MODE, 32'h1, 1'b0);
    rd(`GP_OFF_NS_MODE, 1'b0); chk(rv, 32'h1);
    pads(32'h28);
    pads(32'h8);
    wait_m(1'b0, 1'b1);
    wr(`GP_OFF_LATCH, 32'h20, 1'b0);
    wait_m(1'b0, 1'b0);
    pads(32'h20);
    wait_m(1'b0, 1'b1);
    pads(32'h8);
    wr(`GP_OFF_LATCH, 32'h20, 1'b0);
    wait_m(1'b0, 1'b0);
    wait_m(1'b0, 1'b1);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h8);
    wr(`GP_OFF_LATCH, 32'h8, 1'b0);
    wait_m(1'b0, 1'b0);
    $display("latched test done");
    pin_permission <= 32'h80;
    wr(`GP_OFF_CFG_BASE + 12'h01c, 32'h00020000, 1'b1);
    pads(32'h88);
    wait_m(1'b1, 1'b1);
    chk({31'h0, ns_m}, 32'h0);
    rd(`GP_OFF_LATCH, 1'b0); chk(rv, 32'h0);
    pads(32'h8);
    wr(`GP_OFF_LATCH, 32'h80, 1'b0);
    rd(`GP_OFF_LATCH, 1'b1); chk(rv, 32'h80);
    wr(`GP_OFF_LATCH, 32'h80, 1'b1);
    rd(`GP_OFF_LATCH, 1'b1); chk(rv, 32'h0);
    wr(`GP_OFF_OUT, 32'h0, 1'b1);
    wr(`GP_OFF_OUT, 32'hffffffff, 1'b0);
    rd(`GP_OFF_OUT, 1'b1); chk(rv, vis(32'hffffffff, 1'b0));
    rd(`GP_OFF_CFG_BASE + 12'h01c, 1'b0); chk(rv, 32'h0);
    wr(`GP_OFF_CFG_BASE + 12'h01c, 32'h0, 1'b0);
    rd(`GP_OFF_CFG_BASE + 12'h01c, 1'b1); chk(rv, 32'h00020000);
    wr(`GP_OFF_S_MODE, 32'h1, 1'b0);
    rd(`GP_OFF_S_MODE, 1'b1); chk(rv, 32'h0);
    wr(`GP_OFF_S_MODE, 32'h1, 1'b1);
    rd(`GP_OFF_S_MODE, 1'b1); chk(rv, 32'h1);
    pads(32'h88);
    wait_m(1'b1, 1'b1);
    pads(32'h8);
    chk({31'h0, s_m}, 32'h1);
    rd(12'h100, 1'b1); chk(rv, 32'h0);
    $display("security test done");
    conclude();
  end
endmodule : gpio_pin_sense_security_tb
